// *** core/ils_pkg.sv ***
// ils_pkg: constants, register map and types of the interrupt log/replay block
// assumes one system clock and a plain strobe-based register port
package ils_pkg;
  localparam int ILS_AW = 8;
  localparam int ILS_DW = 32;
  localparam int ILS_LINES = 3;
  // register byte offsets
  localparam logic [ILS_AW-1:0] ILS_CTRL_OFS = 8'h00;
  localparam logic [ILS_AW-1:0] ILS_STAT_OFS = 8'h04;
  localparam logic [ILS_AW-1:0] ILS_MASK_OFS = 8'h08;
  localparam logic [ILS_AW-1:0] ILS_FLAG_OFS = 8'h0c;
  localparam logic [ILS_AW-1:0] ILS_PEND_OFS = 8'h10;
  // control field positions
  localparam int ILS_CTRL_LOG_BIT = 0;
  localparam int ILS_CTRL_T1EN_BIT = 1;
  localparam int ILS_CTRL_T2EN_BIT = 2;
  // status field positions: three overflow flags, then replay done
  localparam int ILS_STAT_OVF_LSB = 0;
  localparam int ILS_STAT_DONE_BIT = 3;
  localparam int ILS_STAT_W = 4;
  // cpu line numbers
  localparam int ILS_LINE_EXP = 0;
  localparam int ILS_LINE_T1 = 1;
  localparam int ILS_LINE_T2 = 2;
  // reset values
  localparam logic [2:0] ILS_CTRL_RST = 3'h6;
  localparam logic [ILS_STAT_W-1:0] ILS_STAT_RST = 4'h0;
  localparam logic [ILS_STAT_W-1:0] ILS_MASK_RST = 4'h0;
  // pulse widths in system clock cycles
  localparam logic [1:0] ILS_T12_PULSE_CYC = 2'h2;
  localparam logic [1:0] ILS_T0_PULSE_CYC = 2'h1;

  typedef struct packed {
    logic t2IrqEn;
    logic t1IrqEn;
    logic logEn;
  } ils_ctrl_t;

  typedef struct packed {
    logic [ILS_AW-1:0] addr;
    logic [ILS_DW-1:0] wdata;
    logic wr;
    logic rd;
  } ils_req_t;

  typedef enum logic [1:0] {
    ILS_IDLE = 2'b00,
    ILS_LOG = 2'b01,
    ILS_REPLAY = 2'b11
  } ils_state_t;
endpackage

// *** core/ils_irq_log_replay.sv ***
// ils_irq_log_replay: captures interrupts while the core self-test runs
// and reissues them once logging ends; also shapes the timer pulses.
// assumes timer ticks and peripheral requests come from mclk logic.
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/10ps
// Contract
// R01 - during self-test every incoming interrupt is logged, then reissued afterwards
// R02 - interrupt one cycle before logging starts goes straight to the cpu
// R03 - from the enabling cycle on, interrupts are recorded and replayed at completion
// R04 - second and third timer interrupts stay high two consecutive cycles
// R05 - first timer goes through the expander as a one cycle pulse
// R06 - straddling two-cycle pulse is serviced and also replayed, giving a spurious one
// R07 - software clears timer 1/2 irq enables before logging, restores after test
// R08 - software order: save, enable logging, test, restore, end logging
// R09 - software checks overflow flags after test and sets cpu flag bits
// R10 - one pending bit per line, all pending pulsed one cycle at replay
module ils_irq_log_replay #(
  parameter int PERIPH_W = 4
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ils_pkg::ils_req_t busReq,
  output logic [ils_pkg::ILS_DW-1:0] rdata,
  input wire logic timer0Tick,
  input wire logic timer1Tick,
  input wire logic timer2Tick,
  input wire logic [PERIPH_W-1:0] periphIrq,
  output logic [ils_pkg::ILS_LINES-1:0] cpuIrq,
  output logic selfTestLogging,
  output logic irqOut
);
  import ils_pkg::*;

  ils_ctrl_t ctrl_ff, nxt_ctrl;
  ils_state_t state_ff, nxt_state;
  logic [ILS_STAT_W-1:0] stat_ff, nxt_stat;
  logic [ILS_STAT_W-1:0] mask_ff, nxt_mask;
  logic [ILS_LINES-1:0] pend_ff, nxt_pend;
  logic [ILS_LINES-1:0] force_ff, nxt_force;
  logic [ILS_LINES-1:0] cpuIrq_ff, nxt_cpuIrq;
  logic [1:0] t1Cnt_ff, nxt_t1Cnt;
  logic [1:0] t2Cnt_ff, nxt_t2Cnt;
  logic [ILS_DW-1:0] rdata_ff, nxt_rdata;
  logic [ILS_LINES-1:0] rawIrq;
  logic [ILS_LINES-1:0] replayIrq;
  logic wrHit, rdHit;
  logic irqOut_ff, nxt_irqOut;

  function automatic logic hit(input ils_req_t r, input logic [ILS_AW-1:0] ofs);
    hit = (r.addr == ofs);
  endfunction

  // narrow registers read back zero-extended to the bus width
  function automatic logic [ILS_DW-1:0] widen(input logic [ILS_STAT_W-1:0] v);
    widen = '0;
    widen[ILS_STAT_W-1:0] = v;
  endfunction

  function automatic logic [1:0] pulseStep(input logic tick, input logic en,
                                           input logic [1:0] cnt);
    // a fresh tick restarts the full width
    if (tick && en) begin
      pulseStep = ILS_T12_PULSE_CYC; // R04
    end else if (cnt != 2'h0) begin
      pulseStep = cnt - 2'h1;
    end else begin
      pulseStep = 2'h0;
    end
  endfunction

  // timer pulse shaping
  // a disabled timer never reaches its line, its overflow flag still sets
  always_comb begin
    nxt_t1Cnt = pulseStep(timer1Tick, ctrl_ff.t1IrqEn, t1Cnt_ff); // R04
    nxt_t2Cnt = pulseStep(timer2Tick, ctrl_ff.t2IrqEn, t2Cnt_ff); // R04
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      t1Cnt_ff <= 2'h0;
      t2Cnt_ff <= 2'h0;
    end else begin
      t1Cnt_ff <= nxt_t1Cnt;
      t2Cnt_ff <= nxt_t2Cnt;
    end
  end

  // timer 0 is a single tick, width ILS_T0_PULSE_CYC, merged in the expander
  always_comb begin
    rawIrq = '0;
    rawIrq[ILS_LINE_EXP] = timer0Tick | (|periphIrq); // R05
    rawIrq[ILS_LINE_T1] = (t1Cnt_ff != 2'h0); // R04
    rawIrq[ILS_LINE_T2] = (t2Cnt_ff != 2'h0); // R04
  end

  // logging state: idle, logging, one replay cycle
  // re-enable during replay goes straight back to logging
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ILS_IDLE: begin
        if (ctrl_ff.logEn) begin
          nxt_state = ILS_LOG;
        end
      end
      ILS_LOG: begin
        if (!ctrl_ff.logEn) begin
          nxt_state = ILS_REPLAY;
        end
      end
      ILS_REPLAY: begin
        nxt_state = ctrl_ff.logEn ? ILS_LOG : ILS_IDLE;
      end
      default: begin
        nxt_state = ILS_IDLE;
      end
    endcase
  end

  assign replayIrq = (state_ff == ILS_REPLAY) ? pend_ff : '0; // R10

  // capture starts with the very cycle logEn reads high; the cycle
  // before still reaches the cpu, so a straddling timer pulse is both
  // serviced and logged -- software masks timers 1/2 to avoid it
  always_comb begin
    nxt_pend = pend_ff;
    // a re-enable in the replay cycle silences the cpu lines, so the
    // pending bits are kept for the next replay instead of being lost
    if (state_ff == ILS_REPLAY && !ctrl_ff.logEn) begin
      nxt_pend = '0; // R10
    end
    if (ctrl_ff.logEn) begin
      nxt_pend = nxt_pend | rawIrq; // R01 R03 R06 R10
    end
  end

  // cpu lines are silenced while logging, replay and forced flags join in
  // a flag forced while logging is dropped; raise it after the test
  always_comb begin
    if (ctrl_ff.logEn) begin
      nxt_cpuIrq = '0; // R01
    end else begin
      nxt_cpuIrq = rawIrq | replayIrq | force_ff; // R02 R03 R09
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      state_ff <= ILS_IDLE;
      pend_ff <= '0;
      cpuIrq_ff <= '0;
    end else begin
      state_ff <= nxt_state;
      pend_ff <= nxt_pend;
      cpuIrq_ff <= nxt_cpuIrq;
    end
  end

  // register port
  // unmapped reads and the write-only flag word return zero
  assign wrHit = busReq.wr;
  assign rdHit = busReq.rd;

  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_force = '0;
    nxt_stat = stat_ff;
    nxt_rdata = '0;
    if (wrHit && hit(busReq, ILS_CTRL_OFS)) begin
      nxt_ctrl = busReq.wdata[2:0]; // R07 R08
    end
    if (wrHit && hit(busReq, ILS_MASK_OFS)) begin
      nxt_mask = busReq.wdata[ILS_STAT_W-1:0];
    end
    if (wrHit && hit(busReq, ILS_FLAG_OFS)) begin
      nxt_force = busReq.wdata[ILS_LINES-1:0]; // R09
    end
    if (rdHit) begin
      if (hit(busReq, ILS_CTRL_OFS)) begin
        nxt_rdata = widen({1'h0, ctrl_ff});
      end else if (hit(busReq, ILS_STAT_OFS)) begin
        nxt_rdata = widen(stat_ff);
        nxt_stat = '0;
      end else if (hit(busReq, ILS_MASK_OFS)) begin
        nxt_rdata = widen(mask_ff);
      end else if (hit(busReq, ILS_PEND_OFS)) begin
        nxt_rdata = widen({1'h0, pend_ff});
      end
    end
    // hardware set wins over a read clear in the same cycle
    nxt_stat[ILS_STAT_OVF_LSB] = nxt_stat[ILS_STAT_OVF_LSB] | timer0Tick;
    nxt_stat[ILS_STAT_OVF_LSB+1] = nxt_stat[ILS_STAT_OVF_LSB+1] | timer1Tick; // R09
    nxt_stat[ILS_STAT_OVF_LSB+2] = nxt_stat[ILS_STAT_OVF_LSB+2] | timer2Tick; // R09
    nxt_stat[ILS_STAT_DONE_BIT] = nxt_stat[ILS_STAT_DONE_BIT] |
                                  (state_ff == ILS_REPLAY && !ctrl_ff.logEn);
    // from next values, so the level moves together with the status bits
    nxt_irqOut = |(nxt_stat & nxt_mask);
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrl_ff <= ILS_CTRL_RST;
      mask_ff <= ILS_MASK_RST;
      stat_ff <= ILS_STAT_RST;
      force_ff <= '0;
      rdata_ff <= '0;
      irqOut_ff <= 1'h0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      force_ff <= nxt_force;
      rdata_ff <= nxt_rdata;
      irqOut_ff <= nxt_irqOut;
    end
  end

  assign rdata = rdata_ff;
  assign cpuIrq = cpuIrq_ff;
  assign selfTestLogging = ctrl_ff.logEn;
  assign irqOut = irqOut_ff;
endmodule

// *** verif/ils_irq_src_model.sv ***
// ils_irq_src_model: timer sources and the cpu interrupt inputs
// assumes one-cycle fire requests from the bench, all on mclk
`timescale 1ns/10ps
module ils_irq_src_model (
  input wire logic mclk,
  input wire logic [2:0] fire,
  input wire logic [2:0] cpuIrq,
  output logic [2:0] tick,
  output logic [7:0] hits [3]
);
  // cycles high are counted, so a stretched or doubled pulse shows up
  initial begin
    tick = 3'h0;
    hits = '{8'h0, 8'h0, 8'h0};
  end
  always @(posedge mclk) begin
    tick <= fire;
    for (int i = 0; i < 3; i++) hits[i] <= hits[i] + 8'(cpuIrq[i]);
  end
endmodule

// *** verif/ils_irq_log_replay_assertions.sv ***
// ils_chk: port checks of the interrupt log/replay block
// assumes only mclk/sys_rst; ctrl and mask are mirrored from bus writes
`timescale 1ns/10ps
module ils_chk import ils_pkg::*; #(parameter int PERIPH_W = 4) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire ils_pkg::ils_req_t busReq,
  input wire logic [ils_pkg::ILS_DW-1:0] rdata,
  input wire logic timer0Tick,
  input wire logic timer1Tick,
  input wire logic timer2Tick,
  input wire logic [PERIPH_W-1:0] periphIrq,
  input wire logic [ils_pkg::ILS_LINES-1:0] cpuIrq,
  input wire logic selfTestLogging,
  input wire logic irqOut
);
  logic [2:0] en_ff, nxt_en;
  logic [3:0] msk_ff, nxt_msk;
  always_comb begin
    nxt_en = en_ff;
    nxt_msk = msk_ff;
    if (busReq.wr && busReq.addr == ILS_CTRL_OFS) nxt_en = busReq.wdata[2:0];
    if (busReq.wr && busReq.addr == ILS_MASK_OFS) nxt_msk = busReq.wdata[3:0];
  end
  always_ff @(posedge mclk) begin
    en_ff <= sys_rst ? ILS_CTRL_RST : nxt_en;
    msk_ff <= sys_rst ? ILS_MASK_RST : nxt_msk;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  a_t0_pulse: assert property (timer0Tick && !selfTestLogging |=> cpuIrq[0])
    else $error("t0 lost");
  a_t1_width: assert property (timer1Tick && en_ff[1] ##1 !selfTestLogging[*2]
    |-> cpuIrq[1] ##1 cpuIrq[1]) else $error("t1 width");
  // first logging cycle may still carry the straddled pulse
  a_log_hold: assert property (selfTestLogging && $past(selfTestLogging)
    && !$past(busReq.wr) |-> cpuIrq == '0) else $error("irq while logging");
  a_log_follow: assert property (busReq.wr && busReq.addr == ILS_CTRL_OFS
    |=> selfTestLogging == $past(busReq.wdata[0])) else $error("log level");
  a_replay_once: assert property ($fell(selfTestLogging) ##2 cpuIrq[0] && !timer0Tick
    && periphIrq == '0 && !$past(busReq.wr) |=> !cpuIrq[0]) else $error("replay width");
  a_rd_idle: assert property (!$past(busReq.rd) |-> rdata == '0)
    else $error("rdata idle");
  a_rd_unmapped: assert property (busReq.rd && busReq.addr > ILS_PEND_OFS |=> rdata == '0)
    else $error("unmapped read");
  a_irq_masked: assert property (msk_ff == '0 |-> !irqOut) else $error("masked irq");
endmodule
bind ils_irq_log_replay ils_chk #(.PERIPH_W(PERIPH_W)) chk (.mclk(mclk), .sys_rst(sys_rst),
  .busReq(busReq), .rdata(rdata), .timer0Tick(timer0Tick), .timer1Tick(timer1Tick),
  .timer2Tick(timer2Tick), .periphIrq(periphIrq), .cpuIrq(cpuIrq),
  .selfTestLogging(selfTestLogging), .irqOut(irqOut));

// *** verif/tb_irq_log_replay_selftest.sv ***
// tb_irq_log_replay_selftest: self-checking bench of the log/replay block
// assumes the source model drives the ticks and counts cpu cycles high
`timescale 1ns/10ps
module tb_irq_log_replay_selftest;
  import ils_pkg::*;
  typedef struct packed {logic [2:0] f; logic lg; logic [11:0] e;} ils_row_t;
  logic mclk, sys_rst, stl, irqOut;
  ils_req_t req;
  logic [ILS_DW-1:0] rdata;
  logic [2:0] fire, tick, cpuIrq;
  logic [3:0] periph;
  logic [7:0] hits [3];
  logic [7:0] base [3];
  int err_count, comparisons;
  ils_row_t rows [5] = '{'{3'h1, 1'h0, 12'h001}, '{3'h2, 1'h0, 12'h020},
    '{3'h4, 1'h0, 12'h200}, '{3'h7, 1'h1, 12'h111}, '{3'h2, 1'h1, 12'h010}};
  ils_irq_log_replay dut (.mclk(mclk), .sys_rst(sys_rst), .busReq(req), .rdata(rdata),
    .timer0Tick(tick[0]), .timer1Tick(tick[1]), .timer2Tick(tick[2]), .periphIrq(periph),
    .cpuIrq(cpuIrq), .selfTestLogging(stl), .irqOut(irqOut));
  ils_irq_src_model src (.mclk(mclk), .fire(fire), .cpuIrq(cpuIrq), .tick(tick), .hits(hits));
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s: expected %h, seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk) req <= '{a, d, 1'h1, 1'h0};
    @(posedge mclk) req.wr <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk) req <= '{a, 32'h0, 1'h0, 1'h1};
    @(posedge mclk) req.rd <= 1'h0;
    #1 cmp("rdata", e, rdata);
  endtask
  task automatic pulse(input logic [2:0] f);
    @(posedge mclk) fire <= f;
    @(posedge mclk) fire <= 3'h0;
  endtask
  function automatic logic [31:0] dl();
    return {20'h0, 4'(hits[2] - base[2]), 4'(hits[1] - base[1]), 4'(hits[0] - base[0])};
  endfunction
  task automatic final_report;
    $display("mismatches %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    mclk = 1'h0;
    forever #10 mclk = ~mclk;
  end
  initial begin
    #50us;
    err_count++;
    final_report;
  end
  initial begin
    sys_rst = 1'h1;
    req = '0;
    fire = 3'h0;
    periph = 4'h0;
    repeat (16) @(posedge mclk);
    sys_rst <= 1'h0;
    foreach (rows[i]) begin
      base = hits;
      if (rows[i].lg) wr(ILS_CTRL_OFS, 32'h7);
      pulse(rows[i].f);
      repeat (4) @(posedge mclk);
      if (rows[i].lg) wr(ILS_CTRL_OFS, 32'h6);
      repeat (6) @(posedge mclk);
      cmp("hits", 32'(rows[i].e), dl());
    end
    // mid-run reset must bring back every register value
    @(posedge mclk) sys_rst <= 1'h1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'h0;
    #1 cmp("reset outputs", 32'h0, 32'({cpuIrq, stl, irqOut}));
    rd(ILS_CTRL_OFS, 32'h6);
    rd(ILS_STAT_OFS, 32'h0);
    rd(ILS_MASK_OFS, 32'h0);
    rd(ILS_PEND_OFS, 32'h0);
    wr(8'h20, 32'hffffffff);
    rd(8'h20, 32'h0);
    rd(ILS_FLAG_OFS, 32'h0);
    // d=0 straddles the enabling edge, d=1 lands wholly before it
    for (int d = 0; d < 2; d++) begin
      base = hits;
      pulse(3'h2);
      repeat (d) @(posedge mclk);
      wr(ILS_CTRL_OFS, 32'h7);
      #1 cmp("selfTestLogging", 32'h1, 32'(stl));
      rd(ILS_PEND_OFS, d ? 32'h0 : 32'h2);
      wr(ILS_CTRL_OFS, 32'h6);
      repeat (6) @(posedge mclk);
      cmp("hits", 32'h020, dl());
    end
    rd(ILS_STAT_OFS, 32'ha);
    wr(ILS_CTRL_OFS, 32'h0);
    wr(ILS_CTRL_OFS, 32'h1);
    base = hits;
    pulse(3'h6);
    rd(ILS_PEND_OFS, 32'h0);
    wr(ILS_CTRL_OFS, 32'h0);
    repeat (4) @(posedge mclk);
    rd(ILS_STAT_OFS, 32'he);
    wr(ILS_FLAG_OFS, 32'h6);
    repeat (3) @(posedge mclk);
    cmp("hits", 32'h110, dl());
    base = hits;
    @(posedge mclk) periph <= 4'h8;
    @(posedge mclk) periph <= 4'h0;
    repeat (3) @(posedge mclk);
    cmp("hits", 32'h001, dl());
    wr(ILS_CTRL_OFS, 32'h6);
    wr(ILS_MASK_OFS, 32'h2);
    rd(ILS_MASK_OFS, 32'h2);
    for (int m = 0; m < 2; m++) begin
      pulse(m ? 3'h4 : 3'h2);
      repeat (2) @(posedge mclk);
      #1 cmp("irqOut", 32'(!m), 32'(irqOut));
      rd(ILS_STAT_OFS, m ? 32'h4 : 32'h2);
      cmp("irqOut", 32'h0, 32'(irqOut));
    end
    final_report;
  end
endmodule
